// File: rtl/csr_charger_status_regs.sv
// status, fault, regulation-mask and part-information registers of the charger
`timescale 1ns/1ps
`default_nettype none
module csr_charger_status_regs
#(
    // arbitrary identifier value, not tied to any real part
    parameter logic [3:0] PART_ID = 4'h5
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire csr_pkg::csr_bus_req_type bus_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire csr_pkg::csr_cond_type cond,
    input wire logic watchdog_expired,
    input wire logic host_mode_entry,
    output logic host_irq,
    output logic safety_timer_reset,
    output logic register_reset_pulse
);
    import csr_pkg::*;

    // ==========================================
    // declarations
    csr_status_type status;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic watchdog_fault_reg;
    logic watchdog_fault_next;
    csr_rst_state_type rst_state_reg;
    csr_rst_state_type rst_state_next;
    logic rst_wr_hit;
    logic mask_wr_hit;
    logic [7:0] rd_data_next;

    // ==========================================
    // address decode, shared by read and write paths
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        addr_is = (addr == target);
    endfunction

    assign rst_wr_hit = bus_req.wr_en && addr_is(bus_req.addr, ADDR_PART_INFO)
                        && bus_req.wr_data[BIT_REG_RESET];
    assign mask_wr_hit = bus_req.wr_en && addr_is(bus_req.addr, ADDR_INREG_STATUS);

    // ==========================================
    // live status capture
    csr_status_sampler u_sampler
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cond(cond),
        .status(status)
    );

    // ==========================================
    // register reset sequencer
    always_comb
    begin
        rst_state_next = rst_state_reg;
        unique case (rst_state_reg)
            CSR_RST_IDLE:
            begin
                if (rst_wr_hit)
                    rst_state_next = CSR_RST_APPLY;
            end
            CSR_RST_APPLY:
            begin
                // a fresh request in the clearing cycle keeps the bit set
                if (!rst_wr_hit)
                    rst_state_next = CSR_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            rst_state_reg <= CSR_RST_IDLE;
        else
            rst_state_reg <= rst_state_next;
    end

    // the rest of the chip's configuration listens to this pulse
    assign register_reset_pulse = (rst_state_reg == CSR_RST_APPLY);
    assign safety_timer_reset = (rst_state_reg == CSR_RST_APPLY);

    // ==========================================
    // interrupt masks
    always_comb
    begin
        mask_next = mask_reg;
        // register reset takes priority over a write in the same cycle
        if (rst_state_reg == CSR_RST_APPLY)
            mask_next = MASK_DEFAULT;
        else if (mask_wr_hit)
            mask_next = bus_req.wr_data[1:0];
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            mask_reg <= MASK_DEFAULT;
        else
            mask_reg <= mask_next;
    end

    // ==========================================
    // watchdog fault flag
    always_comb
    begin
        watchdog_fault_next = watchdog_fault_reg;
        // expiry wins over a host mode entry in the same cycle
        if (watchdog_expired)
            watchdog_fault_next = 1'b1;
        else if (host_mode_entry)
            watchdog_fault_next = 1'b0;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            watchdog_fault_reg <= WATCHDOG_FAULT_POR;
        else
            watchdog_fault_reg <= watchdog_fault_next;
    end

    // ==========================================
    // interrupt pulse
    csr_irq_pulse
    #(
        .NUM_SRC(2),
        .PULSE_CYCLES(IRQ_PULSE_CYCLES)
    )
    u_irq
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .active({status.input_voltage_regulation_flag, status.input_current_regulation_flag}),
        .mask({mask_reg[BIT_VREG_MASK], mask_reg[BIT_IREG_MASK]}),
        .irq(host_irq)
    );

    // ==========================================
    // read path; reading never changes state
    always_comb
    begin
        rd_data_next = 8'h00;
        if (addr_is(bus_req.addr, ADDR_STATUS_MAIN))
            rd_data_next = {status.input_source_type, status.charge_phase,
                            status.power_good_flag, status.thermal_regulation_flag,
                            status.system_minimum_regulation_flag};
        else if (addr_is(bus_req.addr, ADDR_FAULT_STATUS))
            rd_data_next = {watchdog_fault_reg, 1'b0, status.charge_fault_code,
                            status.battery_overvoltage_flag, status.thermistor_zone_code};
        else if (addr_is(bus_req.addr, ADDR_INREG_STATUS))
            rd_data_next = {status.input_supply_qualified, status.input_voltage_regulation_flag,
                            status.input_current_regulation_flag, 1'b0,
                            status.topoff_timer_running, status.input_overvoltage_flag,
                            mask_reg};
        else if (addr_is(bus_req.addr, ADDR_PART_INFO))
            rd_data_next = {rst_state_reg == CSR_RST_APPLY, PART_ID, PART_RESERVED_BITS};
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            rd_data <= 8'h00;
        else if (bus_req.rd_en)
            rd_data <= rd_data_next;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            rd_valid <= 1'b0;
        else
            rd_valid <= bus_req.rd_en;
    end

    // ==========================================
    // assertions
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence seq_rst_write;
        rst_wr_hit;
    endsequence

    sequence seq_rst_release;
        (rst_state_reg == CSR_RST_APPLY) && !rst_wr_hit;
    endsequence

    a_source_none: assert property (!cond.vbus_present |=> status.input_source_type == SRC_NONE)
        else $error("source type not none without input");

    a_source_usb_adapter: assert property (cond.vbus_present |=>
        status.input_source_type == ($past(cond.psel_high) ? SRC_USB_HOST : SRC_ADAPTER))
        else $error("source type does not follow select pin");

    a_phase_fast: assert property (cond.chg_active && !cond.chg_precharge && !cond.chg_done
        |=> status.charge_phase == PHASE_FAST)
        else $error("fast charge phase not reported");

    // read data holds the fields of the taking edge, which may move on one cycle later
    a_main_readback: assert property (bus_req.rd_en && addr_is(bus_req.addr, ADDR_STATUS_MAIN)
        |=> rd_valid && rd_data[2:0] == $past({status.power_good_flag,
        status.thermal_regulation_flag, status.system_minimum_regulation_flag}))
        else $error("main status readback mismatch");

    a_thermal_follow: assert property (cond.thermal_reg ##1 !cond.thermal_reg
        |-> status.thermal_regulation_flag ##1 !status.thermal_regulation_flag)
        else $error("thermal flag does not follow condition");

    a_watchdog_set: assert property (watchdog_expired |=> watchdog_fault_reg [*1])
        else $error("watchdog fault not set on expiry");

    a_watchdog_clear: assert property (host_mode_entry && !watchdog_expired
        |=> !watchdog_fault_reg)
        else $error("watchdog fault not cleared in host mode");

    a_fault_timer: assert property (cond.safety_timer_expired
        |=> status.charge_fault_code == CFAULT_TIMER)
        else $error("safety timer fault not reported");

    a_battery_fault: assert property (!$past(sys_rst)
        |-> status.battery_overvoltage_flag == $past(cond.battery_ovp))
        else $error("battery fault flag mismatch");

    a_zone_hot: assert property (cond.ts_hot && !cond.ts_cold
        |=> status.thermistor_zone_code == ZONE_HOT)
        else $error("hot zone not reported");

    a_inreg_readback: assert property (bus_req.rd_en && addr_is(bus_req.addr, ADDR_INREG_STATUS)
        |=> rd_data[7:2] == $past({status.input_supply_qualified, status.input_voltage_regulation_flag,
        status.input_current_regulation_flag, 1'b0, status.topoff_timer_running,
        status.input_overvoltage_flag}))
        else $error("regulation status readback mismatch");

    a_vreg_irq: assert property ($rose(status.input_voltage_regulation_flag) && !mask_reg[BIT_VREG_MASK]
        |=> host_irq)
        else $error("unmasked voltage regulation gave no interrupt");

    a_ireg_irq: assert property ($rose(status.input_current_regulation_flag) && !mask_reg[BIT_IREG_MASK]
        |=> host_irq)
        else $error("unmasked current regulation gave no interrupt");

    // a pulse started just before masking may still show in the eighth masked cycle
    a_irq_masked: assert property ((mask_reg == 2'h3) [*8] |=> !host_irq)
        else $error("interrupt while both sources masked");

    a_rst_timer: assert property (seq_rst_write |=> safety_timer_reset && register_reset_pulse)
        else $error("register reset did not reset safety timer");

    a_rst_self_clear: assert property (seq_rst_write ##1 seq_rst_release
        |=> rst_state_reg == CSR_RST_IDLE && mask_reg == MASK_DEFAULT)
        else $error("register reset bit did not self-clear");

    a_read_no_effect: assert property (bus_req.rd_en && !bus_req.wr_en && !host_mode_entry
        && !watchdog_expired && rst_state_reg == CSR_RST_IDLE
        |=> $stable(mask_reg) && $stable(watchdog_fault_reg))
        else $error("read changed register contents");

    a_phase_precharge: assert property (cond.chg_active && cond.chg_precharge && !cond.chg_done
        |=> status.charge_phase == PHASE_PRECHARGE)
        else $error("precharge phase not reported");

    a_phase_done: assert property (cond.chg_done |=> status.charge_phase == PHASE_DONE)
        else $error("terminated phase not reported");

    a_phase_idle: assert property (!cond.chg_active && !cond.chg_done
        |=> status.charge_phase == PHASE_IDLE)
        else $error("idle phase not reported");

    a_power_good: assert property (!$past(sys_rst)
        |-> status.power_good_flag == $past(cond.power_good))
        else $error("power good flag mismatch");

    a_sysmin_follow: assert property (!$past(sys_rst)
        |-> status.system_minimum_regulation_flag == $past(cond.vbat_below_sysmin))
        else $error("system minimum flag mismatch");

    a_fault_thermal: assert property (cond.thermal_shutdown && !cond.safety_timer_expired
        |=> status.charge_fault_code == CFAULT_THERMAL)
        else $error("thermal shutdown fault not reported");

    a_fault_input: assert property (cond.input_fault && !cond.thermal_shutdown && !cond.safety_timer_expired
        |=> status.charge_fault_code == CFAULT_INPUT)
        else $error("input fault not reported");

    a_fault_none: assert property (!cond.input_fault && !cond.thermal_shutdown && !cond.safety_timer_expired
        |=> status.charge_fault_code == CFAULT_NONE)
        else $error("charge fault reported without cause");

    a_zone_cold: assert property (cond.ts_cold |=> status.thermistor_zone_code == ZONE_COLD)
        else $error("cold zone not reported");

    a_zone_normal: assert property (!cond.ts_cold && !cond.ts_hot && !cond.ts_cool && !cond.ts_warm
        |=> status.thermistor_zone_code == ZONE_NORMAL)
        else $error("zone reported without cause");

    a_supply_qualified: assert property (!$past(sys_rst)
        |-> status.input_supply_qualified == $past(cond.vbus_good))
        else $error("input supply flag mismatch");

    a_topoff_follow: assert property (!$past(sys_rst)
        |-> status.topoff_timer_running == $past(cond.topoff_running))
        else $error("top-off flag mismatch");

    a_acov_follow: assert property (!$past(sys_rst)
        |-> status.input_overvoltage_flag == $past(cond.acov_active))
        else $error("input overvoltage flag mismatch");

    a_irq_width: assert property ($rose(host_irq) |-> host_irq [*8])
        else $error("interrupt pulse shorter than its width");

    a_mask_write: assert property (mask_wr_hit && rst_state_reg == CSR_RST_IDLE
        |=> mask_reg == $past(bus_req.wr_data[1:0]))
        else $error("mask write not taken");

    a_wd_readback: assert property (bus_req.rd_en && addr_is(bus_req.addr, ADDR_FAULT_STATUS)
        |=> rd_data[7] == $past(watchdog_fault_reg))
        else $error("watchdog fault readback mismatch");

    a_part_readback: assert property (bus_req.rd_en && addr_is(bus_req.addr, ADDR_PART_INFO)
        |=> rd_data[6:0] == {PART_ID, PART_RESERVED_BITS})
        else $error("part information readback mismatch");

    a_rd_valid_set: assert property (bus_req.rd_en |=> rd_valid)
        else $error("read gave no valid strobe");

    a_rd_valid_clear: assert property (!bus_req.rd_en |=> !rd_valid)
        else $error("valid strobe without read");
endmodule
`default_nettype wire

// File: rtl/csr_irq_pulse.sv
// turns entry into unmasked regulation states into a fixed-width interrupt pulse
`timescale 1ns/1ps
`default_nettype none
module csr_irq_pulse
#(
    parameter int NUM_SRC = 2,
    parameter int PULSE_CYCLES = csr_pkg::IRQ_PULSE_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [NUM_SRC-1:0] active,
    input wire logic [NUM_SRC-1:0] mask,
    output logic irq
);
    import csr_pkg::*;
    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
    logic [NUM_SRC-1:0] active_prev_reg;
    logic [NUM_SRC-1:0] start;
    logic [CNT_W-1:0] count_reg;
    if (PULSE_CYCLES < 1 || NUM_SRC < 1)
        $error("csr_irq_pulse: pulse width and source count must be at least one");
    // ==========================================
    // edge detect per source
    for (genvar i = 0; i < NUM_SRC; i++)
    begin : g_src
        assign start[i] = active[i] && !active_prev_reg[i] && !mask[i];
    end
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            active_prev_reg <= '0;
        else
            active_prev_reg <= active;
    end
    // ==========================================
    // pulse stretch; a new entry restarts the pulse
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count_reg <= '0;
            irq <= 1'b0;
        end
        else if (|start)
        begin
            count_reg <= CNT_W'(PULSE_CYCLES - 1);
            irq <= 1'b1;
        end
        else
        begin
            if (count_reg != '0)
                count_reg <= count_reg - 1'b1;
            irq <= (count_reg != '0);
        end
    end
endmodule
`default_nettype wire

// File: rtl/csr_pkg.sv
// constants and carrier types of the charger status register bank
`default_nettype none
package csr_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] ADDR_STATUS_MAIN = 8'h08;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h09;
    localparam logic [7:0] ADDR_INREG_STATUS = 8'h0A;
    localparam logic [7:0] ADDR_PART_INFO = 8'h0B;
    // ==========================================
    // field positions
    localparam int BIT_WATCHDOG_FAULT = 7;
    localparam int BIT_REG_RESET = 7;
    localparam int BIT_VREG_MASK = 1;
    localparam int BIT_IREG_MASK = 0;
    // ==========================================
    // field encodings
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_USB_HOST = 3'h1;
    localparam logic [2:0] SRC_ADAPTER = 3'h3;
    localparam logic [1:0] PHASE_IDLE = 2'h0;
    localparam logic [1:0] PHASE_PRECHARGE = 2'h1;
    localparam logic [1:0] PHASE_FAST = 2'h2;
    localparam logic [1:0] PHASE_DONE = 2'h3;
    localparam logic [1:0] CFAULT_NONE = 2'h0;
    localparam logic [1:0] CFAULT_INPUT = 2'h1;
    localparam logic [1:0] CFAULT_THERMAL = 2'h2;
    localparam logic [1:0] CFAULT_TIMER = 2'h3;
    localparam logic [2:0] ZONE_NORMAL = 3'h0;
    localparam logic [2:0] ZONE_WARM = 3'h2;
    localparam logic [2:0] ZONE_COOL = 3'h3;
    localparam logic [2:0] ZONE_COLD = 3'h5;
    localparam logic [2:0] ZONE_HOT = 3'h6;
    // ==========================================
    // values after reset and counts
    localparam logic [1:0] MASK_DEFAULT = 2'h0;
    localparam logic WATCHDOG_FAULT_POR = 1'b1;
    localparam logic [2:0] PART_RESERVED_BITS = 3'h4;
    localparam int IRQ_PULSE_CYCLES = 8;
    // ==========================================
    // carrier types
    typedef struct packed {
        logic [7:0] addr;
        logic wr_en;
        logic rd_en;
        logic [7:0] wr_data;
    } csr_bus_req_type;
    typedef struct packed {
        logic vbus_present;
        logic psel_high;
        logic chg_active;
        logic chg_precharge;
        logic chg_done;
        logic power_good;
        logic thermal_reg;
        logic vbat_below_sysmin;
        logic input_fault;
        logic thermal_shutdown;
        logic safety_timer_expired;
        logic battery_ovp;
        logic ts_warm;
        logic ts_cool;
        logic ts_cold;
        logic ts_hot;
        logic vbus_good;
        logic vindpm_active;
        logic iindpm_active;
        logic topoff_running;
        logic acov_active;
    } csr_cond_type;
    typedef struct packed {
        logic [2:0] input_source_type;
        logic [1:0] charge_phase;
        logic power_good_flag;
        logic thermal_regulation_flag;
        logic system_minimum_regulation_flag;
        logic [1:0] charge_fault_code;
        logic battery_overvoltage_flag;
        logic [2:0] thermistor_zone_code;
        logic input_supply_qualified;
        logic input_voltage_regulation_flag;
        logic input_current_regulation_flag;
        logic topoff_timer_running;
        logic input_overvoltage_flag;
    } csr_status_type;
    typedef enum logic {CSR_RST_IDLE, CSR_RST_APPLY} csr_rst_state_type;
endpackage
`default_nettype wire

// File: rtl/csr_status_sampler.sv
// encodes live charger conditions into registered status fields
`timescale 1ns/1ps
`default_nettype none
module csr_status_sampler
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire csr_pkg::csr_cond_type cond,
    output csr_pkg::csr_status_type status
);
    import csr_pkg::*;
    csr_status_type status_next;
    // ==========================================
    // encoding
    always_comb
    begin
        status_next = '0;
        if (cond.vbus_present)
        begin
            // only the select pin decides; a software limit never shows here
            status_next.input_source_type = cond.psel_high ? SRC_USB_HOST : SRC_ADAPTER;
        end
        if (cond.chg_done)
            status_next.charge_phase = PHASE_DONE;
        else if (cond.chg_active)
            status_next.charge_phase = cond.chg_precharge ? PHASE_PRECHARGE : PHASE_FAST;
        status_next.power_good_flag = cond.power_good;
        status_next.thermal_regulation_flag = cond.thermal_reg;
        status_next.system_minimum_regulation_flag = cond.vbat_below_sysmin;
        // worst fault wins when several are present
        if (cond.safety_timer_expired)
            status_next.charge_fault_code = CFAULT_TIMER;
        else if (cond.thermal_shutdown)
            status_next.charge_fault_code = CFAULT_THERMAL;
        else if (cond.input_fault)
            status_next.charge_fault_code = CFAULT_INPUT;
        status_next.battery_overvoltage_flag = cond.battery_ovp;
        if (cond.ts_cold)
            status_next.thermistor_zone_code = ZONE_COLD;
        else if (cond.ts_hot)
            status_next.thermistor_zone_code = ZONE_HOT;
        else if (cond.ts_cool)
            status_next.thermistor_zone_code = ZONE_COOL;
        else if (cond.ts_warm)
            status_next.thermistor_zone_code = ZONE_WARM;
        status_next.input_supply_qualified = cond.vbus_good;
        status_next.input_voltage_regulation_flag = cond.vindpm_active;
        status_next.input_current_regulation_flag = cond.iindpm_active;
        status_next.topoff_timer_running = cond.topoff_running;
        status_next.input_overvoltage_flag = cond.acov_active;
    end
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            status <= '0;
        else
            status <= status_next;
    end
endmodule
`default_nettype wire

// File: tb/csr_host_model.sv
// host side model: drives register reads and writes on the bank's request port
`timescale 1ns/1ps
`default_nettype none
module csr_host_model
(
    input wire logic clk_sys,
    output csr_pkg::csr_bus_req_type bus_req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    import csr_pkg::*;
    // ==========================================
    // idle request lines carry inverted leftovers so a stale value is never mistaken for a live one
    initial bus_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus_req.addr = a;
        bus_req.wr_data = d;
        bus_req.wr_en = 1'b1;
        @(negedge clk_sys);
        bus_req.wr_en = 1'b0;
        bus_req.addr = ~a;
        bus_req.wr_data = ~d;
    endtask
    // read answer is taken one edge after the request edge, together with rd_valid
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys);
        bus_req.addr = a;
        bus_req.rd_en = 1'b1;
        @(negedge clk_sys);
        d = rd_data;
        v = rd_valid;
        bus_req.rd_en = 1'b0;
        bus_req.addr = ~a;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_csr_charger_status_regs.sv
// self-checking bench for the charger status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_csr_charger_status_regs;
    import csr_pkg::*;
    // arbitrary identifier value
    localparam logic [3:0] PID = 4'h5;
    logic clk_sys, sys_rst, watchdog_expired, host_mode_entry;
    logic host_irq, safety_timer_reset, register_reset_pulse, rd_valid;
    logic [7:0] rd_data;
    csr_bus_req_type bus_req;
    csr_cond_type cond, c;
    int failures = 0;
    int checked = 0;
    // ==========================================
    // instances
    csr_charger_status_regs #(.PART_ID(PID)) csr_charger_status_regs_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .bus_req(bus_req), .rd_data(rd_data), .rd_valid(rd_valid), .cond(cond), .watchdog_expired(watchdog_expired),
        .host_mode_entry(host_mode_entry), .host_irq(host_irq), .safety_timer_reset(safety_timer_reset),
        .register_reset_pulse(register_reset_pulse));
    csr_host_model csr_host_model_inst (.clk_sys(clk_sys), .bus_req(bus_req), .rd_data(rd_data), .rd_valid(rd_valid));
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ==========================================
    // helpers
    task automatic conclude();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        csr_host_model_inst.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask
    task automatic sc(input logic [7:0] a, input csr_cond_type k, input logic [7:0] e);
        @(negedge clk_sys);
        cond = k;
        rchk(a, e);
    endtask
    // counts interrupt cycles after a condition change; a long window also catches a stuck output
    task automatic irq_cnt(input csr_cond_type k, input int e);
        int n;
        n = 0;
        @(negedge clk_sys);
        cond = k;
        repeat (20)
        begin
            @(negedge clk_sys);
            if (host_irq === 1'b1)
                n++;
        end
        `CHK(n, e)
        @(negedge clk_sys);
        cond = '0;
        repeat (12) @(negedge clk_sys);
    endtask
    task automatic pulse(input bit wd);
        @(negedge clk_sys);
        if (wd)
            watchdog_expired = 1'b1;
        else
            host_mode_entry = 1'b1;
        @(negedge clk_sys);
        watchdog_expired = 1'b0;
        host_mode_entry = 1'b0;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        failures++;
        $display("BAD %0t timeout", $time);
        conclude();
    end
    // ==========================================
    // tests
    initial
    begin
        sys_rst = 1'b1;
        cond = '0;
        watchdog_expired = 1'b0;
        host_mode_entry = 1'b0;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        rchk(8'h09, 8'h80);
        rchk(8'h0A, 8'h00);
        rchk(8'h0B, {1'b0, PID, 3'b100});
        rchk(8'h20, 8'h00);
        c = '0; c.vbus_present = 1; c.psel_high = 1; sc(8'h08, c, 8'h20);
        c.psel_high = 0; sc(8'h08, c, 8'h60);
        csr_host_model_inst.wr(8'h08, 8'hFF);
        rchk(8'h08, 8'h60);
        c = '0; sc(8'h08, c, 8'h00);
        c.chg_active = 1; c.chg_precharge = 1; sc(8'h08, c, 8'h08);
        c.chg_precharge = 0; sc(8'h08, c, 8'h10);
        c.chg_done = 1; sc(8'h08, c, 8'h18);
        c = '0; c.power_good = 1; sc(8'h08, c, 8'h04);
        c = '0; c.thermal_reg = 1; sc(8'h08, c, 8'h02);
        c = '0; c.vbat_below_sysmin = 1; sc(8'h08, c, 8'h01);
        c = '0; c.input_fault = 1; sc(8'h09, c, 8'h90);
        c = '0; c.thermal_shutdown = 1; sc(8'h09, c, 8'hA0);
        c = '0; c.safety_timer_expired = 1; sc(8'h09, c, 8'hB0);
        c = '0; c.battery_ovp = 1; sc(8'h09, c, 8'h88);
        c = '0; c.ts_warm = 1; sc(8'h09, c, 8'h82);
        c = '0; c.ts_cool = 1; sc(8'h09, c, 8'h83);
        c = '0; c.ts_cold = 1; sc(8'h09, c, 8'h85);
        c = '0; c.ts_hot = 1; sc(8'h09, c, 8'h86);
        c = '0; sc(8'h09, c, 8'h80);
        pulse(1'b0);
        rchk(8'h09, 8'h00);
        csr_host_model_inst.wr(8'h09, 8'hFF);
        pulse(1'b1);
        rchk(8'h09, 8'h80);
        c = '0; c.vbus_good = 1; sc(8'h0A, c, 8'h80);
        c = '0; c.topoff_running = 1; sc(8'h0A, c, 8'h08);
        c = '0; c.acov_active = 1; sc(8'h0A, c, 8'h04);
        c = '0; sc(8'h0A, c, 8'h00);
        c.vindpm_active = 1; irq_cnt(c, IRQ_PULSE_CYCLES);
        c = '0; c.iindpm_active = 1; irq_cnt(c, IRQ_PULSE_CYCLES);
        csr_host_model_inst.wr(8'h0A, 8'hFF);
        c = '0; c.iindpm_active = 1; sc(8'h0A, c, 8'h23);
        c = '0; sc(8'h0A, c, 8'h03);
        c.iindpm_active = 1; irq_cnt(c, 0);
        c = '0; c.vindpm_active = 1; irq_cnt(c, 0);
        csr_host_model_inst.wr(8'h0A, 8'h01);
        c = '0; c.vindpm_active = 1; sc(8'h0A, c, 8'h41);
        // the entry above starts a pulse; let it run out before counting again
        repeat (12) @(negedge clk_sys);
        c = '0; c.iindpm_active = 1; irq_cnt(c, 0);
        c = '0; c.vindpm_active = 1; irq_cnt(c, IRQ_PULSE_CYCLES);
        csr_host_model_inst.wr(8'h0B, 8'h7F);
        rchk(8'h0B, {1'b0, PID, 3'b100});
        csr_host_model_inst.wr(8'h0B, 8'h80);
        `CHK(safety_timer_reset, 1'b1)
        `CHK(register_reset_pulse, 1'b1)
        rchk(8'h0A, 8'h00);
        rchk(8'h0B, {1'b0, PID, 3'b100});
        `CHK(safety_timer_reset, 1'b0)
        c = '0; c.iindpm_active = 1; irq_cnt(c, IRQ_PULSE_CYCLES);
        conclude();
    end
endmodule
`default_nettype wire
